/* verilog/tcp_timer.sv */
// Purpose: 8-bit timer-counter with two compare channels and PWM generation
// Assumes: APB slave, one clock, inputs synchronous to clock
// Notes: Interrupt requests leave as levels; the processor's service ack clears overflow
`timescale 1ns/1ns
`include "tcp_regs.svh"

module tcp_timer #(
	parameter int DATA_W = 8
) (
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt requests and service acknowledge
	input wire logic ovf_service_ack,
	output logic ovf_irq,
	output logic cmp_a_irq,
	output logic cmp_b_irq,
	// Waveform outputs
	output logic wave_out_a,
	output logic wave_out_b,
	output logic wave_out_a_en,
	output logic wave_out_b_en,
	output tcp_pkg::tcp_mode_t wave_mode_sel
);
	import tcp_pkg::*;

	// Every control register, count and compare below is a byte wide, so refuse any other width
	if (DATA_W != 8)
	begin : g_bad_width
		$error("tcp_timer supports only an 8-bit counter");
	end

	logic [7:0] timer_ctrl_a;
	logic [7:0] timer_ctrl_b;
	logic [7:0] count_value;
	logic [7:0] compare_value_a;
	logic [7:0] compare_value_b;
	logic [7:0] buf_a;
	logic [7:0] buf_b;
	logic [2:0] int_mask;
	logic [2:0] timer_flag_reg;
	logic count_down;
	logic [9:0] presc;
	logic wave_a;
	logic wave_b;
	logic [7:0] next_ctrl_a;
	logic [7:0] next_ctrl_b;
	logic [7:0] next_count;
	logic [7:0] next_cmp_a;
	logic [7:0] next_cmp_b;
	logic [7:0] next_buf_a;
	logic [7:0] next_buf_b;
	logic [2:0] next_mask;
	logic [2:0] next_flags;
	logic next_down;
	logic [9:0] next_presc;
	logic next_wave_a;
	logic next_wave_b;
	logic [31:0] next_prdata;

	tcp_mode_t mode;
	tcp_com_t com_a;
	tcp_com_t com_b;
	logic is_fast;
	logic is_pc;
	logic is_pwm;
	logic tick;
	logic [7:0] top;
	logic at_top;
	logic wr;
	logic rd;
	logic hit;
	logic ovf_ev;
	logic match_a;
	logic match_b;

	assign mode = tcp_mode_t'({timer_ctrl_b[`TCP_WGM_HI_BIT],
		timer_ctrl_a[`TCP_WGM_LO_HI:`TCP_WGM_LO_LO]});
	assign com_a = tcp_com_t'(timer_ctrl_a[`TCP_COM_A_HI:`TCP_COM_A_LO]);
	assign com_b = tcp_com_t'(timer_ctrl_a[`TCP_COM_B_HI:`TCP_COM_B_LO]);
	assign is_fast = (mode == TCP_FAST_MAX) || (mode == TCP_FAST_OCR);
	assign is_pc = (mode == TCP_PC_MAX) || (mode == TCP_PC_OCR);
	assign is_pwm = is_fast || is_pc;
	// Top is FF, or compare A in the compare-topped modes
	assign top = (mode == TCP_CTC || mode == TCP_FAST_OCR || mode == TCP_PC_OCR)
		? compare_value_a : `TCP_MAX;
	assign at_top = (count_value == top);
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign wave_mode_sel = mode;

	// Prescaler tap: tick when the divider's low bits are all ones
	function automatic logic presc_tick(input tcp_clksel_t cs, input logic [9:0] p);
		case (cs)
			TCP_CS_1: presc_tick = 1'b1;
			TCP_CS_8: presc_tick = (p & `TCP_DIV_8) == `TCP_DIV_8;
			TCP_CS_64: presc_tick = (p & `TCP_DIV_64) == `TCP_DIV_64;
			TCP_CS_256: presc_tick = (p & `TCP_DIV_256) == `TCP_DIV_256;
			TCP_CS_1024: presc_tick = (p & `TCP_DIV_1024) == `TCP_DIV_1024;
			default: presc_tick = 1'b0;
		endcase
	endfunction : presc_tick

	// Level a channel shows after a PWM match; mode 2 clears on up-count match
	function automatic logic pwm_match_level(input tcp_com_t com, input logic down);
		pwm_match_level = (com == TCP_COM_SET) ^ down;
	endfunction : pwm_match_level

	// Waveform update for one channel
	function automatic logic wave_next(input logic cur, input tcp_com_t com,
		input logic match, input logic restart, input logic fast, input logic pc,
		input logic down, input logic [7:0] cmp);
		wave_next = cur;
		if (com == TCP_COM_OFF)
			wave_next = cur;
		else if (fast)
		begin
			// Max compare never meets a restart first, so the level stays constant
			if (match && cmp != `TCP_MAX)
				wave_next = (com == TCP_COM_SET);
			else if (match)
				wave_next = (com == TCP_COM_SET);
			else if (restart)
				wave_next = (com != TCP_COM_SET);
		end
		else if (pc)
		begin
			if (match)
				wave_next = pwm_match_level(com, down);
		end
		else if (match && com == TCP_COM_TOGGLE)
			wave_next = !cur;
	endfunction : wave_next

	// Divider group: it never stops, so a rate change takes effect without a restart
	always_comb
	begin
		next_presc = 10'(presc + 10'h001);
		tick = presc_tick(tcp_clksel_t'(timer_ctrl_b[`TCP_CS_HI:`TCP_CS_LO]), presc);
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			presc <= 10'h000;
		else
			presc <= next_presc;
	end

	// Counter, compare and register group
	always_comb
	begin
		next_ctrl_a = timer_ctrl_a;
		next_ctrl_b = timer_ctrl_b;
		next_count = count_value;
		next_down = count_down;
		next_cmp_a = compare_value_a;
		next_cmp_b = compare_value_b;
		next_buf_a = buf_a;
		next_buf_b = buf_b;
		next_mask = int_mask;
		next_flags = timer_flag_reg;
		ovf_ev = 1'b0;
		match_a = tick && (count_value == compare_value_a);
		match_b = tick && (count_value == compare_value_b);
		if (tick)
		begin
			if (is_pc)
			begin
				// Turn at each extreme so each is held for a single tick
				if (!count_down && at_top)
				begin
					next_down = 1'b1;
					next_count = 8'(count_value - 8'h01);
					next_cmp_a = buf_a;
					next_cmp_b = buf_b;
				end
				else if (count_down && count_value == `TCP_BOTTOM)
				begin
					next_down = 1'b0;
					next_count = 8'(count_value + 8'h01);
				end
				else if (count_down)
					next_count = 8'(count_value - 8'h01);
				else
					next_count = 8'(count_value + 8'h01);
				if (count_down && count_value == 8'h01)
					ovf_ev = 1'b1;
			end
			else if (is_fast && at_top)
			begin
				next_count = `TCP_BOTTOM;
				next_cmp_a = buf_a;
				next_cmp_b = buf_b;
				ovf_ev = 1'b1;
			end
			else if (mode == TCP_CTC && at_top)
				next_count = `TCP_BOTTOM;
			else
			begin
				// Compare set below the count is missed until the wrap
				next_count = 8'(count_value + 8'h01);
				if (count_value == `TCP_MAX)
					ovf_ev = 1'b1;
			end
		end
		// A stale direction would start the next up/down mode on the falling slope
		if (!is_pc)
			next_down = 1'b0;
		if (!is_pwm)
		begin
			next_buf_a = compare_value_a;
			next_buf_b = compare_value_b;
		end
		if (wr)
		begin
			if (paddr == `TCP_OFF_CTRL_A)
				next_ctrl_a = pwdata[7:0];
			else if (paddr == `TCP_OFF_CTRL_B)
				next_ctrl_b = pwdata[7:0];
			else if (paddr == `TCP_OFF_COUNT)
				next_count = pwdata[7:0];
			else if (paddr == `TCP_OFF_CMP_A)
			begin
				next_buf_a = pwdata[7:0];
				if (!is_pwm)
					next_cmp_a = pwdata[7:0];
			end
			else if (paddr == `TCP_OFF_CMP_B)
			begin
				next_buf_b = pwdata[7:0];
				if (!is_pwm)
					next_cmp_b = pwdata[7:0];
			end
			else if (paddr == `TCP_OFF_IMASK)
				next_mask = pwdata[2:0];
			else if (paddr == `TCP_OFF_FLAGS)
				next_flags = next_flags & ~pwdata[2:0];
		end
		if (ovf_service_ack)
			next_flags[`TCP_FLAG_OVF] = 1'b0;
		// Set wins over a clear in the same cycle
		if (ovf_ev)
			next_flags[`TCP_FLAG_OVF] = 1'b1;
		if (match_a)
			next_flags[`TCP_FLAG_CMPA] = 1'b1;
		if (match_b)
			next_flags[`TCP_FLAG_CMPB] = 1'b1;
	end

	// Waveform group: levels move only on a count tick
	always_comb
	begin
		next_wave_a = wave_a;
		next_wave_b = wave_b;
		if (tick)
		begin
			next_wave_a = wave_next(wave_a, com_a, match_a, at_top, is_fast, is_pc,
				count_down, compare_value_a);
			next_wave_b = wave_next(wave_b, com_b, match_b, at_top, is_fast,
				is_pc, count_down, compare_value_b);
		end
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wave_a <= 1'b0;
			wave_b <= 1'b0;
			wave_out_a <= 1'b0;
			wave_out_b <= 1'b0;
		end
		else
		begin
			wave_a <= next_wave_a;
			wave_b <= next_wave_b;
			wave_out_a <= next_wave_a;
			wave_out_b <= next_wave_b;
		end
	end

	always_comb
	begin
		hit = 1'b1;
		next_prdata = 32'h00000000;
		if (paddr == `TCP_OFF_CTRL_A)
			next_prdata[7:0] = timer_ctrl_a;
		else if (paddr == `TCP_OFF_CTRL_B)
			next_prdata[7:0] = timer_ctrl_b;
		else if (paddr == `TCP_OFF_COUNT)
			next_prdata[7:0] = count_value;
		else if (paddr == `TCP_OFF_CMP_A)
			next_prdata[7:0] = buf_a;
		else if (paddr == `TCP_OFF_CMP_B)
			next_prdata[7:0] = buf_b;
		else if (paddr == `TCP_OFF_IMASK)
			next_prdata[2:0] = int_mask;
		else if (paddr == `TCP_OFF_FLAGS)
			next_prdata[2:0] = timer_flag_reg;
		else
			hit = 1'b0;
	end

	assign pslverr = psel && penable && !hit;
	assign ovf_irq = timer_flag_reg[`TCP_FLAG_OVF] && int_mask[`TCP_FLAG_OVF];
	assign cmp_a_irq = timer_flag_reg[`TCP_FLAG_CMPA] && int_mask[`TCP_FLAG_CMPA];
	assign cmp_b_irq = timer_flag_reg[`TCP_FLAG_CMPB] && int_mask[`TCP_FLAG_CMPB];
	// Enables follow the output mode; pin direction remains with software
	assign wave_out_a_en = (com_a != TCP_COM_OFF);
	assign wave_out_b_en = (com_b != TCP_COM_OFF);

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timer_ctrl_a <= `TCP_RESET_BYTE;
			timer_ctrl_b <= `TCP_RESET_BYTE;
			count_value <= `TCP_RESET_BYTE;
			compare_value_a <= `TCP_RESET_BYTE;
			compare_value_b <= `TCP_RESET_BYTE;
			buf_a <= `TCP_RESET_BYTE;
			buf_b <= `TCP_RESET_BYTE;
			int_mask <= 3'h0;
			timer_flag_reg <= 3'h0;
			count_down <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			timer_ctrl_a <= next_ctrl_a;
			timer_ctrl_b <= next_ctrl_b;
			count_value <= next_count;
			compare_value_a <= next_cmp_a;
			compare_value_b <= next_cmp_b;
			buf_a <= next_buf_a;
			buf_b <= next_buf_b;
			int_mask <= next_mask;
			timer_flag_reg <= next_flags;
			count_down <= next_down;
			if (rd)
				prdata <= next_prdata;
		end
	end

endmodule : tcp_timer

/* verilog/tcp_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing counts of the timer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

`define TCP_OFF_CTRL_A 12'h000
`define TCP_OFF_CTRL_B 12'h004
`define TCP_OFF_COUNT 12'h008
`define TCP_OFF_CMP_A 12'h00C
`define TCP_OFF_CMP_B 12'h010
`define TCP_OFF_IMASK 12'h014
`define TCP_OFF_FLAGS 12'h018
`define TCP_OFF_SERVICE 12'h01C

// Control A: [7:6] compare_out_mode A, [5:4] compare_out_mode B, [1:0] mode low bits
`define TCP_COM_A_HI 7
`define TCP_COM_A_LO 6
`define TCP_COM_B_HI 5
`define TCP_COM_B_LO 4
`define TCP_WGM_LO_HI 1
`define TCP_WGM_LO_LO 0
// Control B: [3] mode high bit, [2:0] clock select
`define TCP_WGM_HI_BIT 3
`define TCP_CS_HI 2
`define TCP_CS_LO 0
// Flags and mask: [0] overflow, [1] compare A, [2] compare B
`define TCP_FLAG_OVF 0
`define TCP_FLAG_CMPA 1
`define TCP_FLAG_CMPB 2

`define TCP_RESET_BYTE 8'h00
`define TCP_BOTTOM 8'h00
`define TCP_MAX 8'hFF

// Prescale factors; counter wraps at the largest
`define TCP_DIV_8 10'h007
`define TCP_DIV_64 10'h03F
`define TCP_DIV_256 10'h0FF
`define TCP_DIV_1024 10'h3FF

`endif

/* verilog/tcp_pkg.sv */
// Purpose: Types shared by the timer design
// Assumes: Constants live in tcp_regs.svh
// Notes: Mode encodings follow the three-bit mode field
package tcp_pkg;

	typedef enum logic [2:0] {
		TCP_NORMAL = 3'h0,
		TCP_PC_MAX = 3'h1,
		TCP_CTC = 3'h2,
		TCP_FAST_MAX = 3'h3,
		TCP_RSV4 = 3'h4,
		TCP_PC_OCR = 3'h5,
		TCP_RSV6 = 3'h6,
		TCP_FAST_OCR = 3'h7
	} tcp_mode_t;

	typedef enum logic [2:0] {
		TCP_CS_STOP = 3'h0,
		TCP_CS_1 = 3'h1,
		TCP_CS_8 = 3'h2,
		TCP_CS_64 = 3'h3,
		TCP_CS_256 = 3'h4,
		TCP_CS_1024 = 3'h5
	} tcp_clksel_t;

	typedef enum logic [1:0] {
		TCP_COM_OFF = 2'h0,
		TCP_COM_TOGGLE = 2'h1,
		TCP_COM_CLEAR = 2'h2,
		TCP_COM_SET = 2'h3
	} tcp_com_t;

endpackage : tcp_pkg

/* sim/tcp_checker.sv */
// Purpose: Port assertions for tcp_timer
// Assumes: Zero-wait APB slave
// Notes: Bound at the foot
`timescale 1ns/1ns
module tcp_checker (
	// System
	input wire logic clock,
	input wire logic sys_rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Events and mode
	input wire logic ovf_service_ack,
	input wire logic ovf_irq,
	input wire logic cmp_a_irq,
	input wire tcp_pkg::tcp_mode_t wave_mode_sel
);
	import tcp_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic acc;
	assign acc = psel && penable;
	a_ready_always: assert property (pready) else $error("pready low");
	a_unmapped_err: assert property (acc && paddr == 12'h01C |-> pslverr) else $error("no error");
	a_mapped_ok: assert property (acc && paddr < 12'h01C |-> !pslverr) else $error("bad error");
	a_err_access: assert property (pslverr |-> acc) else $error("stray error");
	a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper");
	a_ovf_fall: assert property ($fell(ovf_irq) |->
		$past(ovf_service_ack) || $past(acc && pwrite)) else $error("overflow lost");
	a_cmp_hold: assert property (cmp_a_irq && !(acc && pwrite) |=> cmp_a_irq)
		else $error("compare lost");
	a_mode_stable: assert property (!(acc && pwrite) |=> $stable(wave_mode_sel))
		else $error("mode moved");
	c_ovf: cover property ($rose(ovf_irq));
	c_cmp: cover property ($rose(cmp_a_irq));
	c_err: cover property (pslverr);
endmodule : tcp_checker

bind tcp_timer tcp_checker u_tcp_checker (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr,
	.prdata, .pready, .pslverr, .ovf_service_ack, .ovf_irq, .cmp_a_irq, .wave_mode_sel);

/* sim/tcp_pin_load.sv */
// Purpose: Pins loaded by the waveform outputs
// Assumes: Pull-down on each pin
// Notes: Level seen outside the device
`timescale 1ns/1ns
module tcp_pin_load (
	// From the timer
	input wire logic wave_out_a,
	input wire logic wave_out_b,
	input wire logic wave_out_a_en,
	input wire logic wave_out_b_en,
	// Pin levels
	output logic pin_a,
	output logic pin_b
);
	// Undriven pin falls to the pull-down
	assign pin_a = wave_out_a_en ? wave_out_a : 1'b0;
	assign pin_b = wave_out_b_en ? wave_out_b : 1'b0;
endmodule : tcp_pin_load

/* sim/tcp_timer_bench.sv */
// Purpose: Self-checking bench for tcp_timer
// Assumes: Zero-wait APB
// Notes: Waveforms judged at the pins
`timescale 1ns/1ns
`include "tcp_regs.svh"
module tcp_timer_bench;
	import tcp_pkg::*;
	logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, ovf_service_ack = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, ovf_irq, cmp_a_irq, cmp_b_irq, pin_a, pin_b;
	logic wave_out_a, wave_out_b, wave_out_a_en, wave_out_b_en;
	tcp_mode_t wave_mode_sel;
	int errors = 0, n_compared = 0, cyc = 0;
	always #5 clock = ~clock;
	tcp_timer u_tcp_timer (.clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ovf_service_ack, .ovf_irq, .cmp_a_irq, .cmp_b_irq, .wave_out_a,
		.wave_out_b, .wave_out_a_en, .wave_out_b_en, .wave_mode_sel);
	tcp_pin_load u_tcp_pin_load (.wave_out_a, .wave_out_b, .wave_out_a_en, .wave_out_b_en,
		.pin_a, .pin_b);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic print_verdict;
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1, a, {24'h0, d}, q, e);
	endtask : wr
	// Normal mode first so compare writes land at once
	task automatic cfg(input logic [7:0] ca, cb, a, b);
		wr(`TCP_OFF_CTRL_B, 8'h00);
		wr(`TCP_OFF_CTRL_A, 8'h00);
		// Stale flags from the last scenario would let the flag checks pass unearned
		wr(`TCP_OFF_FLAGS, 8'h07);
		wr(`TCP_OFF_COUNT, 8'h00);
		wr(`TCP_OFF_CMP_A, a);
		wr(`TCP_OFF_CMP_B, b);
		wr(`TCP_OFF_CTRL_A, ca);
		wr(`TCP_OFF_CTRL_B, cb);
	endtask : cfg
	// Length of the third run of the pin level; the first run may be partial
	task automatic meas(input bit ch, output int n, output logic lv);
		for (int k = 0; k < 3; k++)
		begin
			lv = ch ? pin_b : pin_a;
			n = 0;
			while ((ch ? pin_b : pin_a) === lv && n < 40000)
			begin
				// Sample away from the edge that launches the pin level
				@(negedge clock);
				n++;
			end
		end
	endtask : meas
	task automatic pwm(input logic [7:0] ca, cb, b, input int hi, lo);
		int n;
		logic lv;
		cfg(ca, cb, 8'h7F, b);
		meas(1, n, lv);
		chk(n, lv ? hi : lo);
	endtask : pwm
	task automatic s_regs;
		logic [31:0] q;
		logic e;
		for (int a = 0; a < 8; a++)
		begin
			apb(0, 12'(a * 4), 0, q, e);
			chk(q, 0);
			chk(e, a == 7);
		end
	endtask : s_regs
	task automatic s_normal;
		logic [31:0] q;
		logic e;
		cfg(8'h00, 8'h00, 8'h00, 8'h00);
		wr(`TCP_OFF_COUNT, 8'hFE);
		apb(0, `TCP_OFF_COUNT, 0, q, e);
		chk(q, 32'hFE);
		wr(`TCP_OFF_IMASK, 8'h01);
		wr(`TCP_OFF_CTRL_B, 8'h01);
		repeat (4) @(posedge clock);
		chk(ovf_irq, 1);
		ovf_service_ack <= 1;
		@(posedge clock);
		ovf_service_ack <= 0;
		@(posedge clock);
		chk(ovf_irq, 0);
		repeat (260) @(posedge clock);
		chk(ovf_irq, 1);
		wr(`TCP_OFF_FLAGS, 8'h01);
		@(posedge clock);
		chk(ovf_irq, 0);
	endtask : s_normal
	task automatic s_ctc;
		int n;
		logic lv;
		cfg(8'h42, 8'h01, 8'h03, 8'h00);
		wr(`TCP_OFF_IMASK, 8'h02);
		meas(0, n, lv);
		chk(n, 4);
		chk(cmp_a_irq, 1);
		wr(`TCP_OFF_CTRL_B, 8'h00);
		wr(`TCP_OFF_FLAGS, 8'h02);
		@(posedge clock);
		chk(cmp_a_irq, 0);
		wr(`TCP_OFF_COUNT, 8'h10);
		wr(`TCP_OFF_CMP_A, 8'h05);
		wr(`TCP_OFF_CTRL_B, 8'h01);
		repeat (200) @(posedge clock);
		chk(cmp_a_irq, 0);
		repeat (60) @(posedge clock);
		chk(cmp_a_irq, 1);
	endtask : s_ctc
	task automatic s_fast;
		pwm(8'h23, 8'h01, 8'h40, 65, 191);
		pwm(8'h23, 8'h09, 8'h40, 65, 63);
		chk(wave_mode_sel, TCP_FAST_OCR);
		pwm(8'h23, 8'h09, 8'h00, 1, 127);
	endtask : s_fast
	task automatic s_phase;
		pwm(8'h21, 8'h01, 8'h40, 128, 382);
		pwm(8'h21, 8'h09, 8'h40, 128, 126);
	endtask : s_phase
	task automatic s_prescale;
		int n;
		logic lv;
		logic [31:0] q;
		logic e;
		for (int c = 1; c < 4; c++)
		begin
			cfg(8'h40, 8'(c), 8'h00, 8'h00);
			meas(0, n, lv);
			chk(n, 256 << (3 * (c - 1)));
		end
		// Slow rates: ticks over exactly 2048 edges, whole divider turns
		for (int c = 4; c < 6; c++)
		begin
			cfg(8'h00, 8'(c), 8'h00, 8'h00);
			wr(`TCP_OFF_COUNT, 8'h00);
			repeat (2047) @(posedge clock);
			apb(0, `TCP_OFF_COUNT, 0, q, e);
			chk(q, c == 4 ? 8 : 2);
		end
	endtask : s_prescale
	// A second reset in mid-run must bring every register back to zero
	task automatic s_reset;
		@(posedge clock);
		sys_rst <= 1;
		repeat (2) @(posedge clock);
		sys_rst <= 0;
		s_regs;
	endtask : s_reset
	initial
	begin
		repeat (8) @(posedge clock);
		sys_rst <= 0;
		s_regs;
		s_normal;
		s_ctc;
		s_fast;
		s_phase;
		s_prescale;
		s_reset;
		print_verdict;
	end
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			errors++;
			print_verdict;
		end
	end
endmodule : tcp_timer_bench
